// File: svm_defs.svh
// Register map, field positions, reset values and timing counts of the supply monitor.
`ifndef SVM_DEFS_SVH
`define SVM_DEFS_SVH

// Register byte addresses on the APB.
`define SVM_ADDR_CTRL      12'h000
`define SVM_ADDR_IRQF      12'h004
`define SVM_ADDR_STAT      12'h008
`define SVM_ADDR_MASK      12'h00c

// Field positions of voltage_monitor_control.
`define SVM_CTRL_LVL_MSB   2
`define SVM_CTRL_LVL_LSB   0
`define SVM_CTRL_EN_BIT    4
`define SVM_CTRL_FLAG_BIT  5

// Field position of the interrupt request flag register.
`define SVM_IRQF_BIT       0

// Event bits shared by the status and mask registers.
`define SVM_EVT_W          3
`define SVM_EVT_DLY_BIT    0
`define SVM_EVT_RISE_BIT   1
`define SVM_EVT_FALL_BIT   2

// Reset values.
`define SVM_CTRL_RST       8'h00
`define SVM_EVT_RST        3'h0

// Timing: clock period and the interrupt assertion delay, rounded up to cycles.
`define SVM_CLK_NS         40
`define SVM_IRQ_DELAY_NS   18000
`define SVM_IRQ_DELAY_CYC  ((`SVM_IRQ_DELAY_NS + `SVM_CLK_NS - 1) / `SVM_CLK_NS)
`define SVM_CNT_W          16

// Cycles software waits after enabling the detector before it trusts the flag.
// The value is a plain default; the analog settling time decides the real figure.
`define SVM_SETTLE_CYC     4

`endif

// File: svm_pkg.sv
// Types of the supply monitor: trip level codes and delay sequencer states.
package svm_pkg;

	// Trip levels, lowest first; the analog ladder maps each code to its voltage.
	typedef enum logic [2:0] {
		svm_lvl_1v8,
		svm_lvl_2v0,
		svm_lvl_2v4,
		svm_lvl_2v7,
		svm_lvl_3v0,
		svm_lvl_3v3,
		svm_lvl_3v6,
		svm_lvl_4v0
	} svm_trip_t;

	// States of the interrupt assertion delay.
	typedef enum logic [1:0] {
		svm_dly_idle,
		svm_dly_count,
		svm_dly_fired
	} svm_dly_t;

endpackage

// File: svm_sync.sv
// Two-stage synchroniser for the asynchronous comparator output.
`timescale 1ns/1ps
module svm_sync (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Asynchronous level in, synchronous level out.
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta_q;

	// The first stage is read only by the second, so metastability never fans out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// File: svm_top.sv
// Supply voltage monitor control: APB registers, flag, delayed interrupt and wake-up.
// Operation
// - Three-bit code picks one of eight levels.
// - Flag high while supply below threshold.
// - Enable bit switches the detector on/off.
// - Sleep mode forces the detector off.
// - Interrupt only after delay from flag high; irq also rises one cycle after an unmasked flag rise/fall event.
// - Delay expiry sets interrupt request flag.
// - Interrupt request wakes device from idle; wake_req pulses only on expiry in idle while the request flag is clear.
// - Reserved bits zero, flag read-only, reset zero.
// - Repeated flag toggles are handled cleanly.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "svm_defs.svh"
module svm_top
	import svm_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Analog comparator and its controls.
	input  wire logic        cmp_low_async,
	output logic             monitor_on,
	output logic      [2:0]  trip_level_select,
	// Power mode status from the power controller, same clock.
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	// Interrupt and wake-up.
	output logic             irq,
	output logic             wake_req
);

	localparam logic [`SVM_CNT_W-1:0] DLY_LAST = `SVM_CNT_W'(`SVM_IRQ_DELAY_CYC - 1);

	logic                  ctrl_en_q;
	svm_trip_t             ctrl_lvl_q;
	logic                  monitor_on_q;
	logic                  cmp_sync;
	logic                  flag_q;
	logic                  irqf_q;
	svm_dly_t              dly_st_q;
	logic [`SVM_CNT_W-1:0] dly_cnt_q;
	logic                  fire;
	logic [`SVM_EVT_W-1:0] stat_q;
	logic [`SVM_EVT_W-1:0] mask_q;
	logic [`SVM_EVT_W-1:0] stat_set;
	logic [`SVM_EVT_W-1:0] stat_clr_q;
	logic                  irq_q;
	logic                  wake_q;
	logic                  pready_q;
	logic                  pslverr_q;
	logic [31:0]           prdata_q;
	logic [31:0]           rd_val;
	logic                  addr_hit;
	logic                  setup;
	logic                  acc_done;
	logic                  wr_ctrl;
	logic                  wr_irqf;
	logic                  wr_mask;
	logic                  rd_stat_done;
	logic [`SVM_CNT_W-1:0] low_run_q;

	// Bus phase decode; the access completes on the edge where pready is seen high.
	assign setup        = psel && !penable;
	assign acc_done     = psel && penable && pready_q;
	assign addr_hit     = (paddr == `SVM_ADDR_CTRL) || (paddr == `SVM_ADDR_IRQF) ||
	                      (paddr == `SVM_ADDR_STAT) || (paddr == `SVM_ADDR_MASK);
	assign wr_ctrl      = acc_done && pwrite && (paddr == `SVM_ADDR_CTRL);
	assign wr_irqf      = acc_done && pwrite && (paddr == `SVM_ADDR_IRQF);
	assign wr_mask      = acc_done && pwrite && (paddr == `SVM_ADDR_MASK);
	assign rd_stat_done = acc_done && !pwrite && (paddr == `SVM_ADDR_STAT);

	// Read mux; unimplemented and reserved bits read as zero.
	always_comb begin
		rd_val = 32'h0000_0000;
		case (paddr)
			`SVM_ADDR_CTRL: begin
				rd_val[`SVM_CTRL_LVL_MSB:`SVM_CTRL_LVL_LSB] = ctrl_lvl_q;
				rd_val[`SVM_CTRL_EN_BIT]                    = ctrl_en_q;
				rd_val[`SVM_CTRL_FLAG_BIT]                  = flag_q;
			end
			`SVM_ADDR_IRQF: rd_val[`SVM_IRQF_BIT] = irqf_q;
			`SVM_ADDR_STAT: rd_val[`SVM_EVT_W-1:0] = stat_q;
			`SVM_ADDR_MASK: rd_val[`SVM_EVT_W-1:0] = mask_q;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// No wait state: data and the error answer are prepared in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup && !addr_hit;
			if (setup) begin
				prdata_q <= rd_val;
			end
		end
	end

	// Remember which status bits were returned so only those are cleared.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_clr_q <= `SVM_EVT_RST;
		end else if (setup) begin
			stat_clr_q <= (paddr == `SVM_ADDR_STAT) && !pwrite ? stat_q : `SVM_EVT_RST;
		end
	end

	// Control register: enable and threshold are read/write and reset to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_q  <= 1'b0;
			ctrl_lvl_q <= svm_lvl_1v8;
		end else if (wr_ctrl) begin
			ctrl_en_q  <= pwdata[`SVM_CTRL_EN_BIT];
			ctrl_lvl_q <= svm_trip_t'(pwdata[`SVM_CTRL_LVL_MSB:`SVM_CTRL_LVL_LSB]);
		end
	end

	// Detector power and trip code to the analog side; sleep overrides the enable bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			monitor_on_q      <= 1'b0;
			trip_level_select <= 3'h0;
		end else begin
			monitor_on_q      <= ctrl_en_q && !sleep_mode;
			trip_level_select <= ctrl_lvl_q;
		end
	end

	assign monitor_on = monitor_on_q;

	// Comparator crosses into the clock domain here.
	svm_sync u_cmp_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (cmp_low_async),
		.sync_out (cmp_sync)
	);

	// Flag follows the comparator only while the detector is powered.
	// While settling after power-up the comparator may be wrong; software waits it out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= monitor_on_q && cmp_sync;
		end
	end

	// Delay sequencer: any drop of the flag restarts the wait, so chatter near the
	// threshold never produces an early request; a rise held for the full wait requests again.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_st_q  <= svm_dly_idle;
			dly_cnt_q <= '0;
		end else begin
			case (dly_st_q)
				svm_dly_idle: begin
					dly_cnt_q <= '0;
					if (flag_q) begin
						dly_st_q <= svm_dly_count;
					end
				end
				svm_dly_count: begin
					if (!flag_q) begin
						dly_st_q  <= svm_dly_idle;
						dly_cnt_q <= '0;
					end else if (dly_cnt_q == DLY_LAST) begin
						dly_st_q <= svm_dly_fired;
					end else begin
						dly_cnt_q <= dly_cnt_q + 1'b1;
					end
				end
				svm_dly_fired: begin
					if (!flag_q) begin
						dly_st_q  <= svm_dly_idle;
						dly_cnt_q <= '0;
					end
				end
				default: begin
					dly_st_q  <= svm_dly_idle;
					dly_cnt_q <= '0;
				end
			endcase
		end
	end

	assign fire = (dly_st_q == svm_dly_count) && flag_q && (dly_cnt_q == DLY_LAST);

	// Request flag: hardware set wins over a software clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irqf_q <= 1'b0;
		end else if (fire) begin
			irqf_q <= 1'b1;
		end else if (wr_irqf) begin
			irqf_q <= pwdata[`SVM_IRQF_BIT];
		end
	end

	// Wake only on a fresh request; a flag already high means no new edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= fire && idle_mode && !irqf_q;
		end
	end

	assign wake_req = wake_q;

	// Sticky event bits: expiry, flag rise and flag fall.
	always_comb begin
		stat_set                   = `SVM_EVT_RST;
		stat_set[`SVM_EVT_DLY_BIT]  = fire;
		stat_set[`SVM_EVT_RISE_BIT] = monitor_on_q && cmp_sync && !flag_q;
		stat_set[`SVM_EVT_FALL_BIT] = flag_q && !(monitor_on_q && cmp_sync);
	end

	// A read clears what it returned; a new event in the clearing cycle survives.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= `SVM_EVT_RST;
		end else if (rd_stat_done) begin
			stat_q <= (stat_q & ~stat_clr_q) | stat_set;
		end else begin
			stat_q <= stat_q | stat_set;
		end
	end

	// Mask register, same layout as status.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= `SVM_EVT_RST;
		end else if (wr_mask) begin
			mask_q <= pwdata[`SVM_EVT_W-1:0];
		end
	end

	// Level interrupt, one register stage after the status bits.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	assign irq     = irq_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign prdata  = prdata_q;

	// Checking aid: number of consecutive cycles the flag has been high.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_run_q <= '0;
		end else if (!flag_q) begin
			low_run_q <= '0;
		end else if (low_run_q != {`SVM_CNT_W{1'b1}}) begin
			low_run_q <= low_run_q + 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sleep_forces_off: assert property (
		sleep_mode |=> !monitor_on
	) else $error("Detector powered during sleep.");

	a_enable_powers_on: assert property (
		(wr_ctrl && pwdata[`SVM_CTRL_EN_BIT] && !sleep_mode) ##1 !sleep_mode |=> monitor_on
	) else $error("Enable write did not power the detector.");

	a_flag_off_disabled: assert property (
		!monitor_on |=> !flag_q
	) else $error("Flag set while detector off.");

	a_flag_follows_cmp: assert property (
		(monitor_on && cmp_sync) |=> flag_q
	) else $error("Flag missed a low supply.");

	a_fire_after_delay: assert property (
		fire |-> (low_run_q >= `SVM_CNT_W'(`SVM_IRQ_DELAY_CYC))
	) else $error("Request raised before the delay.");

	a_chatter_restart: assert property (
		$fell(flag_q) |=> (dly_st_q == svm_dly_idle) && !fire
	) else $error("Delay not restarted on flag drop.");

	a_fire_sets_flag: assert property (
		fire |=> irqf_q ##1 ((stat_q[`SVM_EVT_DLY_BIT] && mask_q[`SVM_EVT_DLY_BIT]) || !mask_q[`SVM_EVT_DLY_BIT])
	) else $error("Expiry did not set request flag.");

	a_flag_sticky: assert property (
		(irqf_q && !(wr_irqf && !pwdata[`SVM_IRQF_BIT])) |=> irqf_q
	) else $error("Request flag cleared without software.");

	a_wake_on_new: assert property (
		(fire && idle_mode && !irqf_q) |=> wake_req ##1 !wake_req
	) else $error("Idle wake-up missing.");

	a_no_wake_preset: assert property (
		(irqf_q || !fire) |=> !wake_req
	) else $error("Wake-up despite preset request flag.");

	a_reserved_zero: assert property (
		(pready && !pwrite && paddr == `SVM_ADDR_CTRL) |->
			(prdata[31:6] == 26'h0000000) && !prdata[3]
	) else $error("Reserved control bits not zero.");

	a_irq_level: assert property (
		(|(stat_q & mask_q)) |=> irq
	) else $error("Interrupt output missing.");

	a_trip_code: assert property (
		wr_ctrl |=> ##1 (trip_level_select == $past(pwdata[2:0], 2))
	) else $error("Trip code not forwarded.");

endmodule

// File: svm_top_tb.sv
// Self-checking testbench of the supply monitor control block over its APB port.
`timescale 1ns/1ps
`include "svm_defs.svh"
module svm_top_tb;
	import svm_pkg::*;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cmp_low_async;
	logic        monitor_on;
	logic [2:0]  trip_level_select;
	logic        sleep_mode;
	logic        idle_mode;
	logic        irq;
	logic        wake_req;
	int          err_total;
	int          n_checks;
	int          wake_cnt;
	logic [31:0] rd;
	logic        er;

	svm_top dut (
		.pclk              (pclk),
		.presetn           (presetn),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.cmp_low_async     (cmp_low_async),
		.monitor_on        (monitor_on),
		.trip_level_select (trip_level_select),
		.sleep_mode        (sleep_mode),
		.idle_mode         (idle_mode),
		.irq               (irq),
		.wake_req          (wake_req)
	);

	// Clock of 40 ns period.
	always #20 pclk = ~pclk;

	// Wake pulses are counted so that a missing or doubled pulse shows up.
	always @(posedge pclk) begin
		if (wake_req === 1'b1) begin
			wake_cnt <= wake_cnt + 1;
		end
	end

	// Compares one value and records a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; waits for pready with a bound rather than assuming no wait state.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Single place where the run ends.
	task automatic finish_test;
		if (err_total == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the tests need about 1100 cycles.
	initial begin
		cyc(5000);
		err_total++;
		finish_test;
	end

	// Main sequence.
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		cmp_low_async = 1'b0;
		sleep_mode = 1'b0;
		idle_mode = 1'b0;
		err_total = 0;
		n_checks = 0;
		wake_cnt = 0;
		cyc(8);
		presetn <= 1'b1;
		// Reset values of every register, and a refused unmapped access.
		rchk(`SVM_ADDR_CTRL, 32'h0000_0000);
		rchk(`SVM_ADDR_IRQF, 32'h0000_0000);
		rchk(`SVM_ADDR_STAT, 32'h0000_0000);
		rchk(`SVM_ADDR_MASK, 32'h0000_0000);
		rchk(12'h010, 32'h0000_0000);
		chk({31'h0, er}, 32'h1);
		chk({30'h0, irq, wake_req}, 32'h0);
		// Every trip code reaches the ladder and reads back, detector kept off.
		for (int i = 0; i < 8; i++) begin
			xfer(1'b1, `SVM_ADDR_CTRL, i);
			cyc(2);
			chk({29'h0, trip_level_select}, i);
			chk({31'h0, monitor_on}, 32'h0);
			rchk(`SVM_ADDR_CTRL, i);
		end
		// Reserved bits and the read-only flag ignore writes of one.
		xfer(1'b1, `SVM_ADDR_CTRL, 32'hffff_ffff);
		cyc(`SVM_SETTLE_CYC);
		rchk(`SVM_ADDR_CTRL, 32'h0000_0017);
		chk({31'h0, monitor_on}, 32'h1);
		xfer(1'b1, `SVM_ADDR_MASK, 32'h0000_0001);
		idle_mode <= 1'b1;
		// Low supply sets the flag after synchronisation; it toggles cleanly.
		cmp_low_async <= 1'b1;
		cyc(5);
		rchk(`SVM_ADDR_CTRL, 32'h0000_0037);
		cmp_low_async <= 1'b0;
		cyc(5);
		rchk(`SVM_ADDR_CTRL, 32'h0000_0017);
		cmp_low_async <= 1'b1;
		cyc(5);
		rchk(`SVM_ADDR_CTRL, 32'h0000_0037);
		// Sleep forces the detector off, so the flag reads zero.
		sleep_mode <= 1'b1;
		cyc(3);
		chk({31'h0, monitor_on}, 32'h0);
		rchk(`SVM_ADDR_CTRL, 32'h0000_0017);
		sleep_mode <= 1'b0;
		// Request flag must not set before the full delay has passed.
		cyc(440);
		rchk(`SVM_ADDR_IRQF, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0);
		cyc(20);
		rchk(`SVM_ADDR_IRQF, 32'h0000_0001);
		chk({31'h0, irq}, 32'h1);
		chk(wake_cnt, 32'h1);
		// Status read returns all events and clears them, dropping irq.
		rchk(`SVM_ADDR_STAT, 32'h0000_0007);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		rchk(`SVM_ADDR_STAT, 32'h0000_0000);
		// A second episode with the request flag still set gives no wake pulse.
		// Only the edge events are unmasked now, so the fall alone raises irq.
		xfer(1'b1, `SVM_ADDR_MASK, 32'h0000_0006);
		cmp_low_async <= 1'b0;
		cyc(8);
		chk({31'h0, irq}, 32'h1);
		cmp_low_async <= 1'b1;
		cyc(470);
		chk(wake_cnt, 32'h1);
		rchk(`SVM_ADDR_STAT, 32'h0000_0007);
		rchk(`SVM_ADDR_IRQF, 32'h0000_0001);
		xfer(1'b1, `SVM_ADDR_IRQF, 32'h0000_0000);
		rchk(`SVM_ADDR_IRQF, 32'h0000_0000);
		xfer(1'b1, `SVM_ADDR_IRQF, 32'h0000_0001);
		rchk(`SVM_ADDR_IRQF, 32'h0000_0001);
		finish_test;
	end
endmodule
